// ==== ecs_pkg.sv ====
// Shared constants and types of the external bus chip-select sequencer
package ecs_pkg;
   localparam int ECS_NUM_CS = 8;
   localparam int ECS_CS_W = 3;
   localparam int ECS_ADDR_W = 26;
   localparam int ECS_DATA_W = 32;
   localparam int ECS_WS_W = 16;
   localparam int ECS_DC_W = 4;
   localparam int ECS_SIZE_W = 2;

   // Clock plan: clk_sys is the peripheral-bus clock, the bus clock is divided from it
   localparam int ECS_SYS_MHZ = 100;
   localparam int ECS_BUS_MAX_MHZ = 66;
   localparam int ECS_BUS_DIV = 2;
   localparam int ECS_BUS_MHZ = ECS_SYS_MHZ / ECS_BUS_DIV;
   localparam int ECS_DIV_W = 2;
   localparam logic [ECS_DIV_W-1:0] ECS_DIV_LAST = ECS_DIV_W'(ECS_BUS_DIV - 1);
   localparam logic [ECS_DIV_W-1:0] ECS_DIV_HIGH = ECS_DIV_W'(ECS_BUS_DIV / 2);

   // Chip-select pulse is this many bus clocks plus the wait states
   localparam int ECS_CS_BASE_CLKS = 2;
   localparam logic [ECS_WS_W:0] ECS_WS_LOAD_ADD = (ECS_WS_W+1)'(ECS_CS_BASE_CLKS - 1);

   // Values after reset
   localparam logic [ECS_NUM_CS-1:0] ECS_CS_N_RST = 8'hff;
   localparam logic [ECS_ADDR_W-1:0] ECS_ADDR_RST = 26'h0000000;
   localparam logic [ECS_DATA_W-1:0] ECS_DATA_RST = 32'h00000000;
   localparam logic [ECS_SIZE_W-1:0] ECS_SIZE_RST = 2'h0;
   localparam logic [ECS_WS_W:0] ECS_WS_CNT_RST = 17'h00000;
   localparam logic [ECS_DC_W-1:0] ECS_DC_CNT_RST = 4'h0;

   typedef enum logic [1:0] {
      ECS_MODE_LEGACY = 2'h0,
      ECS_MODE_BURST = 2'h1,
      ECS_MODE_MUXED = 2'h2
   } ecs_mode_t;

   typedef enum logic [1:0] {
      ECS_KIND_PLAIN = 2'h0,
      ECS_KIND_WIDE_FLASH = 2'h1,
      ECS_KIND_GRAPHICS_MODE = 2'h2
   } ecs_kind_t;

   typedef enum logic [2:0] {
      ECS_ST_IDLE = 3'h0,
      ECS_ST_SETUP = 3'h1,
      ECS_ST_ACTIVE = 3'h3,
      ECS_ST_HOLD = 3'h2,
      ECS_ST_DEAD = 3'h6
   } ecs_state_t;

   typedef struct packed {
      logic [ECS_CS_W-1:0] cs;
      logic [ECS_ADDR_W-1:0] addr;
      logic write;
      logic [ECS_DATA_W-1:0] wdata;
      logic [ECS_SIZE_W-1:0] size;
   } ecs_req_t;

   typedef struct packed {
      logic [ECS_WS_W-1:0] wait_state_count;
      logic [ECS_DC_W-1:0] dead_cycle_count;
      ecs_kind_t kind;
   } ecs_cs_cfg_t;
endpackage

// ==== ecs_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ecs_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // Flops hold the input relative to its idle level, so reset shows the idle level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d ^ rst_val;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q ^ rst_val;
endmodule // ecs_sync

// ==== ecs_bus_clk.sv ====
// Bus clock divider with a pulse marking each bus clock rising edge
`timescale 1ns/100ps
module ecs_bus_clk
   import ecs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic bus_clk,
   output logic tick
);
   logic [ECS_DIV_W-1:0] div_q;
   logic [ECS_DIV_W-1:0] div_d;

   assign tick = (div_q == ECS_DIV_LAST);
   assign div_d = tick ? '0 : div_q + 1'b1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // Bus clock rises on the edge where tick is high
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_clk <= 1'b0;
      end else begin
         bus_clk <= (div_d < ECS_DIV_HIGH);
      end
   end
endmodule // ecs_bus_clk

// ==== ecs_seq.sv ====
// Non-multiplexed legacy chip-select sequencer of the external bus
//
// Functional notes
// [RULE1] Eight chip-select outputs, each selecting its own region and configuration.
// [RULE2] Bus modes legacy, burst and muxed; this sequencer serves legacy only.
// [RULE3] All timing on the self-made bus clock, which stays at or below 66 MHz.
// [RULE4] Chip select lasts two bus clocks plus the programmed wait states.
// [RULE5] Address valid one peripheral clock to one bus clock before chip select.
// [RULE6] Address held at least one peripheral clock after chip select negates.
// [RULE7] Direction set one bus clock before chip select, held one peripheral clock after.
// [RULE8] Write data out one peripheral clock before and after the chip select.
// [RULE9] After reads, do not drive data for dead cycles plus one bus clock.
// [RULE10] Partner acks no sooner than one bus clock after select, releases promptly.
// [RULE11] Transfer-start strobe precedes chip select, exactly one bus clock wide.
// [RULE12] Size code valid one peripheral clock before select, held one after.
// [RULE13] Acknowledge may end the chip-select pulse before the wait states run out.
// [RULE14] Wait states programmable from 0 to 65535 per chip select.
// [RULE15] Strobe only for wide-flash and graphics kinds; size code only for graphics.
// [RULE16] Dead cycles skipped when another bus module wins arbitration.
// [RULE17] Acknowledge sampled on bus clock rising edges as a synchronous input. The code first passes it through the two-flop synchroniser on clk_sys.
`timescale 1ns/100ps
module ecs_seq
   import ecs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire ecs_mode_t bus_mode,
   input wire ecs_cs_cfg_t [ECS_NUM_CS-1:0] cs_cfg,
   input wire logic arb_other_win,
   input wire logic req_valid,
   output logic req_ready,
   input wire ecs_req_t req,
   output logic done,
   output logic done_by_ack,
   output logic [ECS_DATA_W-1:0] rdata,
   output logic busy,
   output logic bus_free,
   output logic bus_clk_o,
   output logic [ECS_NUM_CS-1:0] cs_n,
   output logic [ECS_ADDR_W-1:0] addr_o,
   output logic rw_o,
   output logic oe_n,
   output logic [ECS_DATA_W-1:0] data_o,
   output logic data_oe,
   input wire logic [ECS_DATA_W-1:0] data_i,
   input wire logic ack_n_i,
   output logic transfer_start_strobe_n,
   output logic [ECS_SIZE_W-1:0] transfer_size_code
);
   // Bus clock stays within the external bus limit
   localparam bit ECS_BUS_OK = (ECS_BUS_MHZ <= ECS_BUS_MAX_MHZ); // [RULE3]

   ecs_state_t state_q;
   ecs_state_t state_d;
   logic tick;
   logic accept;
   logic end_cs;
   logic ack_seen;
   logic ack_n_s;
   logic [ECS_DATA_W-1:0] data_s;
   ecs_req_t cur_q;
   ecs_cs_cfg_t cfg_q;
   ecs_cs_cfg_t cfg_sel;
   logic [ECS_WS_W:0] ws_cnt_q;
   logic [ECS_DC_W-1:0] dc_cnt_q;
   logic dead_needed;
   logic [ECS_NUM_CS-1:0] cs_n_q;
   logic [ECS_ADDR_W-1:0] addr_q;
   logic rw_q;
   logic oe_n_q;
   logic [ECS_DATA_W-1:0] data_q;
   logic data_oe_q;
   logic ts_n_q;
   logic [ECS_SIZE_W-1:0] tsize_q;
   logic done_q;
   logic done_ack_q;
   logic [ECS_DATA_W-1:0] rdata_q;

   ecs_bus_clk u_bus_clk (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus_clk(bus_clk_o),
      .tick(tick)
   );

   // Acknowledge and read data come from pins; idle acknowledge is high
   ecs_sync #(
      .W(ECS_DATA_W + 1)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d({ack_n_i, data_i}),
      .rst_val({1'b1, ECS_DATA_RST}),
      .q({ack_n_s, data_s})
   );

   assign cfg_sel = cs_cfg[req.cs];

   // Only legacy transfers are taken, and only on a bus clock edge
   assign req_ready = (state_q == ECS_ST_IDLE) && tick && (bus_mode == ECS_MODE_LEGACY) && ECS_BUS_OK; // [RULE2] [RULE3]
   assign accept = req_valid && req_ready;

   // Acknowledge looked at only on rising bus clock edges while selected
   assign ack_seen = tick && !ack_n_s; // [RULE17] [RULE10]

   // Pulse ends after 2 + wait states bus clocks, or early on acknowledge
   assign end_cs = (state_q == ECS_ST_ACTIVE) && tick && ((ws_cnt_q == '0) || ack_seen); // [RULE4] [RULE13]

   // Dead cycles follow reads unless another module takes the bus
   assign dead_needed = rw_q && !arb_other_win; // [RULE9] [RULE16]

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ECS_ST_IDLE: begin
            if (accept) begin
               state_d = ECS_ST_SETUP;
            end
         end
         ECS_ST_SETUP: begin
            if (tick) begin
               state_d = ECS_ST_ACTIVE;
            end
         end
         ECS_ST_ACTIVE: begin
            if (end_cs) begin
               state_d = ECS_ST_HOLD;
            end
         end
         ECS_ST_HOLD: begin
            if (tick) begin
               state_d = dead_needed ? ECS_ST_DEAD : ECS_ST_IDLE; // [RULE9] [RULE16]
            end
         end
         ECS_ST_DEAD: begin
            if (arb_other_win) begin
               state_d = ECS_ST_IDLE; // [RULE16]
            end else if (tick && (dc_cnt_q == '0)) begin
               state_d = ECS_ST_IDLE; // [RULE9]
            end
         end
         default: begin
            state_d = ECS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ECS_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Request and its chip-select configuration are held for the whole cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
         cfg_q <= '0;
      end else if (accept) begin
         cur_q <= req;
         cfg_q <= cfg_sel; // [RULE1]
      end
   end

   // Wait-state counter, full 16-bit range plus the base clocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ws_cnt_q <= ECS_WS_CNT_RST;
      end else if ((state_q == ECS_ST_SETUP) && tick) begin
         ws_cnt_q <= {1'b0, cfg_q.wait_state_count} + ECS_WS_LOAD_ADD; // [RULE14] [RULE4]
      end else if ((state_q == ECS_ST_ACTIVE) && tick && (ws_cnt_q != '0)) begin
         ws_cnt_q <= ws_cnt_q - 1'b1; // [RULE4]
      end
   end

   // Dead-cycle counter runs after the hold clock of a read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dc_cnt_q <= ECS_DC_CNT_RST;
      end else if ((state_q == ECS_ST_HOLD) && tick) begin
         dc_cnt_q <= cfg_q.dead_cycle_count; // [RULE9]
      end else if ((state_q == ECS_ST_DEAD) && tick && (dc_cnt_q != '0)) begin
         dc_cnt_q <= dc_cnt_q - 1'b1; // [RULE9]
      end
   end

   // One select line per region
   generate
      for (genvar i = 0; i < ECS_NUM_CS; i++) begin : g_cs
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cs_n_q[i] <= ECS_CS_N_RST[i];
            end else if ((state_q == ECS_ST_SETUP) && tick) begin
               cs_n_q[i] <= (cur_q.cs != ECS_CS_W'(i)); // [RULE1]
            end else if (end_cs) begin
               cs_n_q[i] <= 1'b1; // [RULE4] [RULE13]
            end
         end
      end
   endgenerate

   // Address goes out one bus clock before select and stays until the next transfer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= ECS_ADDR_RST;
      end else if (accept) begin
         addr_q <= req.addr; // [RULE5] [RULE6]
      end
   end

   // Direction: high for read, set with the address
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rw_q <= 1'b1;
      end else if (accept) begin
         rw_q <= !req.write; // [RULE7]
      end
   end

   // Output enable follows the select on reads
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oe_n_q <= 1'b1;
      end else if ((state_q == ECS_ST_SETUP) && tick) begin
         oe_n_q <= !rw_q;
      end else if (end_cs) begin
         oe_n_q <= 1'b1;
      end
   end

   // Write data driven from accept until one bus clock after negation
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= ECS_DATA_RST;
      end else if (accept) begin
         data_q <= req.wdata; // [RULE8]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_oe_q <= 1'b0;
      end else if (accept) begin
         data_oe_q <= req.write; // [RULE8] [RULE9]
      end else if ((state_q == ECS_ST_HOLD) && tick) begin
         data_oe_q <= 1'b0; // [RULE8]
      end
   end

   // Start strobe: one bus clock, ending as the select asserts
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ts_n_q <= 1'b1;
      end else if (accept) begin
         ts_n_q <= !((cfg_sel.kind == ECS_KIND_WIDE_FLASH) ||
                     (cfg_sel.kind == ECS_KIND_GRAPHICS_MODE)); // [RULE11] [RULE15]
      end else if ((state_q == ECS_ST_SETUP) && tick) begin
         ts_n_q <= 1'b1; // [RULE11]
      end
   end

   // Size code only for graphics regions, dropped one bus clock after negation
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tsize_q <= ECS_SIZE_RST;
      end else if (accept) begin
         tsize_q <= (cfg_sel.kind == ECS_KIND_GRAPHICS_MODE) ? req.size : ECS_SIZE_RST; // [RULE12] [RULE15]
      end else if ((state_q == ECS_ST_HOLD) && tick) begin
         tsize_q <= ECS_SIZE_RST; // [RULE12]
      end
   end

   // Read data taken at the negating edge; completion reported for one cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= ECS_DATA_RST;
      end else if (end_cs && rw_q) begin
         rdata_q <= data_s;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         done_ack_q <= 1'b0;
      end else begin
         done_q <= end_cs;
         done_ack_q <= end_cs && ack_seen && (ws_cnt_q != '0); // [RULE13]
      end
   end

   assign cs_n = cs_n_q;
   assign addr_o = addr_q;
   assign rw_o = rw_q;
   assign oe_n = oe_n_q;
   assign data_o = data_q;
   assign data_oe = data_oe_q;
   assign transfer_start_strobe_n = ts_n_q;
   assign transfer_size_code = tsize_q;
   assign rdata = rdata_q;
   assign done = done_q;
   assign done_by_ack = done_ack_q;
   assign busy = (state_q != ECS_ST_IDLE);
   // Shared pins free for another module only while idle; arbitration skips dead cycles but neither refuses nor ends a transfer
   assign bus_free = (state_q == ECS_ST_IDLE); // [RULE16]
endmodule // ecs_seq

// ==== ecs_seq_chk.sv ====
// Assertion checker of the external bus chip-select sequencer
`timescale 1ns/100ps
module ecs_seq_chk
   import ecs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire ecs_mode_t bus_mode,
   input wire ecs_cs_cfg_t [ECS_NUM_CS-1:0] cs_cfg,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire ecs_req_t req,
   input wire logic done,
   input wire logic done_by_ack,
   input wire logic busy,
   input wire logic [ECS_NUM_CS-1:0] cs_n,
   input wire logic [ECS_ADDR_W-1:0] addr_o,
   input wire logic rw_o,
   input wire logic [ECS_DATA_W-1:0] data_o,
   input wire logic data_oe,
   input wire logic transfer_start_strobe_n,
   input wire logic [ECS_SIZE_W-1:0] transfer_size_code
);
   logic cs_on;
   logic [ECS_WS_W-1:0] ws_q;
   logic [ECS_WS_W+1:0] cs_cnt_q;
   assign cs_on = (cs_n != ECS_CS_N_RST);
   // Wait states of the accepted select and the length of its pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ws_q <= '0;
      end else if (req_valid && req_ready) begin
         ws_q <= cs_cfg[req.cs].wait_state_count;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cs_cnt_q <= '0;
      end else if (req_valid && req_ready) begin
         cs_cnt_q <= '0;
      end else if (cs_on) begin
         cs_cnt_q <= cs_cnt_q + 18'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_cs_onehot: assert property ($onehot0(~cs_n))
      else $error("more than one chip select active");
   a_mode_gate: assert property (req_ready |-> bus_mode == ECS_MODE_LEGACY && !busy)
      else $error("request accepted outside idle legacy mode");
   a_cs_width: assert property (done && !done_by_ack |-> cs_cnt_q == 18'({ws_q, 1'b0}) + 18'h4)
      else $error("chip select width differs from wait states plus two");
   a_cs_setup: assert property (req_valid && req_ready |=> !cs_on ##1 !cs_on
      ##1 (cs_on && addr_o == $past(req.addr, 3) && $past(addr_o, 2) == addr_o))
      else $error("address not set up before chip select");
   a_addr_hold: assert property ($fell(cs_on) |=> $stable(addr_o) && $stable(rw_o))
      else $error("address or direction changed after chip select");
   a_rw_setup: assert property ($rose(cs_on) |-> $past(rw_o, 2) == rw_o)
      else $error("direction not set a bus clock before chip select");
   a_wdata_setup: assert property ($rose(cs_on) && !rw_o |-> data_oe && $past(data_oe, 2)
      && $past(data_o, 2) == data_o)
      else $error("write data not set up before chip select");
   a_wdata_hold: assert property ($fell(cs_on) && !rw_o |=> data_oe && $stable(data_o))
      else $error("write data not held after chip select");
   a_read_quiet: assert property (rw_o |-> !data_oe)
      else $error("data driven during a read");
   a_strobe_pulse: assert property ($fell(transfer_start_strobe_n) |=> !transfer_start_strobe_n
      ##1 (transfer_start_strobe_n && $rose(cs_on)))
      else $error("start strobe not one bus clock before chip select");
   a_size_setup: assert property ($rose(cs_on) |-> $past(transfer_size_code, 2) ==
      transfer_size_code)
      else $error("size code not set up before chip select");
   a_size_hold: assert property ($fell(cs_on) |=> $stable(transfer_size_code))
      else $error("size code changed after chip select");
   a_done_timing: assert property (done |-> !cs_on && $past(cs_on))
      else $error("done not in the cycle after chip select negation");
   c_read: cover property (done && rw_o);
   c_write: cover property (done && !rw_o);
   c_ack: cover property (done_by_ack);
   c_strobe: cover property ($fell(transfer_start_strobe_n));
endmodule // ecs_seq_chk

bind ecs_seq ecs_seq_chk u_ecs_seq_chk (.clk_sys(clk_sys), .rst_n(rst_n), .bus_mode(bus_mode),
   .cs_cfg(cs_cfg), .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
   .done_by_ack(done_by_ack), .busy(busy), .cs_n(cs_n), .addr_o(addr_o), .rw_o(rw_o),
   .data_o(data_o), .data_oe(data_oe), .transfer_start_strobe_n(transfer_start_strobe_n),
   .transfer_size_code(transfer_size_code));

// ==== ecs_mem_model.sv ====
// Behavioural memory on the far side of the external bus
`timescale 1ns/100ps
module ecs_mem_model
   import ecs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [ECS_NUM_CS-1:0] cs_n,
   input wire logic [ECS_ADDR_W-1:0] addr_o,
   input wire logic rw_o,
   input wire logic [ECS_DATA_W-1:0] data_o,
   input wire logic [3:0] ack_delay,
   output logic [ECS_DATA_W-1:0] data_i,
   output logic ack_n_i
);
   logic [ECS_DATA_W-1:0] mem [16];
   logic [ECS_DATA_W-1:0] last_q = '0;
   int sel_cyc = 0;
   logic sel;
   assign sel = (cs_n != ECS_CS_N_RST);
   always @(posedge clk_sys) begin
      sel_cyc <= sel ? sel_cyc + 1 : 0;
      last_q <= data_i;
      if (sel && !rw_o) begin
         mem[addr_o[3:0]] <= data_o;
      end
   end
   // Zero delay never acknowledges; ack falls ack_delay bus clocks into the select, pulled up when free
   assign ack_n_i = !(sel && ack_delay != 4'h0 && sel_cyc >= 2 * ack_delay);
   // Released data shows a changing pattern, never the held value
   assign data_i = (sel && rw_o) ? mem[addr_o[3:0]] : ~last_q;
endmodule // ecs_mem_model

// ==== ecs_seq_tb.sv ====
// Self-checking testbench of the external bus chip-select sequencer
`timescale 1ns/100ps
module ecs_seq_tb
   import ecs_pkg::*;
   ;
   typedef struct packed {
      logic [2:0] cs;
      logic [3:0] addr;
      logic write;
      logic [31:0] data;
      logic [15:0] ws;
      ecs_kind_t kind;
      logic [3:0] ack;
      logic arb;
      logic [1:0] size;
   } ecs_row_t;
   logic clk_sys, rst_n, arb_other_win, req_valid, req_ready, done, done_by_ack, busy, bus_free;
   logic bus_clk_o, rw_o, oe_n, data_oe, ack_n_i, transfer_start_strobe_n;
   ecs_mode_t bus_mode;
   ecs_cs_cfg_t [ECS_NUM_CS-1:0] cs_cfg;
   ecs_req_t req;
   logic [ECS_DATA_W-1:0] rdata, data_o, data_i;
   logic [ECS_NUM_CS-1:0] cs_n;
   logic [ECS_ADDR_W-1:0] addr_o;
   logic [ECS_SIZE_W-1:0] transfer_size_code;
   logic [3:0] ack_delay;
   int err_count = 0;
   int checks_done = 0;
   ecs_row_t rows [7] = '{
      '{3'h0, 4'h3, 1'b1, 32'ha5a50001, 16'h0000, ECS_KIND_PLAIN, 4'h0, 1'b0, 2'h1},
      '{3'h0, 4'h3, 1'b0, 32'ha5a50001, 16'h0000, ECS_KIND_PLAIN, 4'h0, 1'b0, 2'h1},
      '{3'h7, 4'h5, 1'b1, 32'h5a5a0002, 16'h0003, ECS_KIND_WIDE_FLASH, 4'h0, 1'b1, 2'h2},
      '{3'h7, 4'h5, 1'b0, 32'h5a5a0002, 16'h0003, ECS_KIND_GRAPHICS_MODE, 4'h0, 1'b0, 2'h3},
      '{3'h2, 4'h5, 1'b0, 32'h5a5a0002, 16'h0014, ECS_KIND_PLAIN, 4'h2, 1'b0, 2'h0},
      '{3'h4, 4'h9, 1'b1, 32'hc3c30003, 16'hffff, ECS_KIND_GRAPHICS_MODE, 4'h1, 1'b1, 2'h2},
      '{3'h4, 4'h9, 1'b0, 32'hc3c30003, 16'h0001, ECS_KIND_PLAIN, 4'h0, 1'b1, 2'h0}};

   ecs_seq u_ecs_seq (.clk_sys(clk_sys), .rst_n(rst_n), .bus_mode(bus_mode), .cs_cfg(cs_cfg),
      .arb_other_win(arb_other_win), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .done(done), .done_by_ack(done_by_ack), .rdata(rdata), .busy(busy), .bus_free(bus_free),
      .bus_clk_o(bus_clk_o), .cs_n(cs_n), .addr_o(addr_o), .rw_o(rw_o), .oe_n(oe_n),
      .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .ack_n_i(ack_n_i),
      .transfer_start_strobe_n(transfer_start_strobe_n), .transfer_size_code(transfer_size_code));
   ecs_mem_model u_ecs_mem_model (.clk_sys(clk_sys), .cs_n(cs_n), .addr_o(addr_o), .rw_o(rw_o),
      .data_o(data_o), .ack_delay(ack_delay), .data_i(data_i), .ack_n_i(ack_n_i));

   always #5 clk_sys = ~clk_sys;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One transfer; returns chip-select cycles and strobe-low cycles seen
   task automatic xfer(input ecs_row_t r, output int wid, output int stb);
      int n;
      cs_cfg[r.cs] <= '{r.ws, 4'h1, r.kind};
      ack_delay <= r.ack;
      arb_other_win <= r.arb;
      req <= '{r.cs, {22'h0, r.addr}, r.write, r.data, r.size};
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      check("bus_clk", 32'h0, {31'h0, bus_clk_o});
      wid = 0;
      stb = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
         if (transfer_start_strobe_n === 1'b0) stb++;
         if (cs_n !== ECS_CS_N_RST) begin
            wid++;
            check("cs_n", {24'h0, ~(8'h1 << r.cs)}, {24'h0, cs_n});
            check("size", (r.kind == ECS_KIND_GRAPHICS_MODE) ? r.size : 2'h0, transfer_size_code);
            check("oe_n", {31'h0, r.write}, {31'h0, oe_n});
         end
      end
      check("done", 32'h1, {31'h0, done});
   endtask

   initial begin
      int wid, stb, n;
      clk_sys = 1'b0;
      rst_n = 1'b0;
      bus_mode = ECS_MODE_LEGACY;
      cs_cfg = '0;
      arb_other_win = 1'b0;
      req_valid = 1'b0;
      req = '0;
      ack_delay = 4'h0;
      repeat (16) @(posedge clk_sys);
      check("reset cs_n", 32'hff, {24'h0, cs_n});
      check("reset idle", 32'h31, {26'h0, bus_free, oe_n, data_oe, bus_clk_o, busy,
         transfer_start_strobe_n});
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         xfer(rows[i], wid, stb);
         if (!rows[i].write) check("rdata", rows[i].data, rdata);
         check("strobe", (rows[i].kind == ECS_KIND_PLAIN) ? 0 : 2, stb);
         check("done_by_ack", 32'(rows[i].ack != 4'h0), {31'h0, done_by_ack});
         if (rows[i].ack == 4'h0) check("cs_width", 2 * (rows[i].ws + 2), wid);
         else check("cs_short", 32'h1, 32'(wid < 2 * (rows[i].ws + 2)));
         // After a read the bus is kept for the hold clock, plus DC+1 bus clocks unless arb is set (DC is 1)
         if (!rows[i].write) begin
            n = 0;
            while (bus_free !== 1'b1 && n < 20) begin
               @(posedge clk_sys);
               n++;
            end
            check("dead_wait", rows[i].arb ? 2 : 2 + 2 * (1 + 1), n);
         end
      end
      // Burst and muxed modes refuse requests
      for (int m = 1; m < 3; m++) begin
         bus_mode <= ecs_mode_t'(m);
         req_valid <= 1'b1;
         repeat (6) begin
            @(posedge clk_sys);
            check("req_ready", 32'h0, {31'h0, req_ready});
         end
      end
      req_valid <= 1'b0;
      bus_mode <= ECS_MODE_LEGACY;
      // Reset in the middle of a long read
      cs_cfg[1] <= '{16'h0064, 4'h1, ECS_KIND_PLAIN};
      req <= '{3'h1, 26'h3, 1'b0, 32'h0, 2'h0};
      req_valid <= 1'b1;
      repeat (12) @(posedge clk_sys);
      req_valid <= 1'b0;
      check("cs active", 32'h1, 32'(cs_n == 8'hfd));
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("abort cs_n", 32'hff, {24'h0, cs_n});
      check("abort busy", 32'h0, {31'h0, busy});
      check("abort rdata", 32'h0, rdata);
      rst_n <= 1'b1;
      xfer(rows[1], wid, stb);
      check("rdata after abort", rows[1].data, rdata);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      check("watchdog", 32'h0, 32'h1);
      give_verdict();
   end
endmodule // ecs_seq_tb
